// ===== design/gpio_pin_consts.vh
// constants shared by the pin control block
`ifndef GPIO_PIN_CONSTS_VH
`define GPIO_PIN_CONSTS_VH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PIN_COUNT 71
`define GROUP_COUNT 9
`define GROUP_WIDTH 8
`define BUS_ADDR_W 8
`define BUS_DATA_W 8

// ----------------------------------------------------------------
// register map (byte offsets)
// ----------------------------------------------------------------
`define ADDR_DATA_FIRST 8'h01
`define ADDR_DATA_LAST 8'h09
`define ADDR_CTL_FIRST 8'h10
`define ADDR_CTL_LAST 8'h56
`define ADDR_OTYPE_FIRST 8'h71
`define ADDR_OTYPE_LAST 8'h79

// ----------------------------------------------------------------
// pin_control fields
// ----------------------------------------------------------------
`define CTL_MODE_HI 7
`define CTL_MODE_LO 6
`define CTL_PULL_BIT 2

// ----------------------------------------------------------------
// pin_mode_field codes
// ----------------------------------------------------------------
`define MODE_ALT 2'h0
`define MODE_OUT 2'h1
`define MODE_IN 2'h2

// ----------------------------------------------------------------
// special pins (flat index = group * 8 + pin)
// ----------------------------------------------------------------
`define PIN_B5 13
`define PIN_B6 14
`define PIN_I5 69
`define PIN_E0 32
`define PIN_E4 36
`define GROUP_B 4'h1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DATA_RESET_B 8'h20
`define DATA_RESET 8'h00
`define OTYPE_RESET 8'h00
`define PULL_DOWN_MASK 71'h00FF000000000000

`endif

// ===== design/gpio_pin_control.v
// per-pin control of the 71-pin general purpose port
//
// Functional notes
// - one control register per pin, 71
// - mode bits 7-6: alt, output, input, reserved
// - alternate mode hands pin to alternate functions
// - output mode drives last written data bit
// - other modes: data stored, pin unaffected
// - data register read returns pin level
// - reset mode: B5 output, B6 alt, others input
// - port E pins 0-4 never drive
// - port I pin 5 control survives warm reset
// - bit 2 pull enable; down on G, else up
// - group output type, used in output mode only
// - type one open-drain, zero push-pull
`timescale 1ns/1ns
`include "gpio_pin_consts.vh"
module gpio_pin_control #(
  parameter [`PIN_COUNT-1:0] PULL_DEFAULT = {`PIN_COUNT{1'b0}}
) (
  input wire clk_i,
  input wire resetn_i,
  input wire warm_rst_i,
  input wire [`BUS_ADDR_W-1:0] addr_i,
  input wire [`BUS_DATA_W-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [`BUS_DATA_W-1:0] rdata_o,
  input wire [`PIN_COUNT-1:0] pin_in_i,
  output wire [`PIN_COUNT-1:0] pin_out_o,
  output wire [`PIN_COUNT-1:0] pin_oe_o,
  output reg [`PIN_COUNT-1:0] pull_en_o,
  output reg [`PIN_COUNT-1:0] pull_down_o,
  output reg [`PIN_COUNT-1:0] alt_en_o,
  output wire [`PIN_COUNT-1:0] alt_in_o,
  input wire [`PIN_COUNT-1:0] alt_out_i,
  input wire [`PIN_COUNT-1:0] alt_oe_i
);
  localparam NPIN = `PIN_COUNT;
  localparam NBIT = `GROUP_COUNT * `GROUP_WIDTH;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function in_range;
    input [`BUS_ADDR_W-1:0] a;
    input [`BUS_ADDR_W-1:0] lo;
    input [`BUS_ADDR_W-1:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  function [1:0] mode_default;
    input integer idx;
    begin
      if (idx == `PIN_B5)
        mode_default = `MODE_OUT;
      else if (idx == `PIN_B6)
        mode_default = `MODE_ALT;
      else
        mode_default = `MODE_IN;
    end
  endfunction

  function [`GROUP_WIDTH-1:0] data_default;
    input integer grp;
    begin
      if (grp == `GROUP_B)
        data_default = `DATA_RESET_B;
      else
        data_default = `DATA_RESET;
    end
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // only mode and pull are stored, so reserved bits cannot steer anything
  reg [2*NPIN-1:0] mode_r;
  reg [NPIN-1:0] pull_r;
  reg [NBIT-1:0] data_r;
  reg [NBIT-1:0] otype_r;
  wire [NPIN-1:0] pin_level;
  wire [NBIT-1:0] level_ext;
  reg [NPIN-1:0] alt_en_nxt;
  integer i;
  // separate loop index so the combinational process owns its own variable
  integer j;

  wire ctl_sel = in_range(addr_i, `ADDR_CTL_FIRST, `ADDR_CTL_LAST);
  wire data_sel = in_range(addr_i, `ADDR_DATA_FIRST, `ADDR_DATA_LAST);
  wire otype_sel = in_range(addr_i, `ADDR_OTYPE_FIRST, `ADDR_OTYPE_LAST);
  wire [`BUS_ADDR_W-1:0] ctl_off = addr_i - `ADDR_CTL_FIRST;
  wire [`BUS_ADDR_W-1:0] data_off = addr_i - `ADDR_DATA_FIRST;
  wire [`BUS_ADDR_W-1:0] otype_off = addr_i - `ADDR_OTYPE_FIRST;
  wire [6:0] ctl_idx = ctl_off[6:0];
  wire [3:0] data_grp = data_off[3:0];
  wire [3:0] otype_grp = otype_off[3:0];

  // ----------------------------------------------------------------
  // register writes, cold and warm reset
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (i = 0; i < NPIN; i = i + 1) begin
        mode_r[2*i +: 2] <= mode_default(i);
      end
      pull_r <= PULL_DEFAULT;
      for (i = 0; i < `GROUP_COUNT; i = i + 1) begin
        data_r[i*`GROUP_WIDTH +: `GROUP_WIDTH] <= data_default(i);
        otype_r[i*`GROUP_WIDTH +: `GROUP_WIDTH] <= `OTYPE_RESET;
      end
    end else if (warm_rst_i) begin
      for (i = 0; i < NPIN; i = i + 1) begin
        if (i != `PIN_I5) begin
          mode_r[2*i +: 2] <= mode_default(i);
          pull_r[i] <= PULL_DEFAULT[i];
        end
      end
      for (i = 0; i < `GROUP_COUNT; i = i + 1) begin
        data_r[i*`GROUP_WIDTH +: `GROUP_WIDTH] <= data_default(i);
        otype_r[i*`GROUP_WIDTH +: `GROUP_WIDTH] <= `OTYPE_RESET;
      end
    end else if (wr_i) begin
      if (ctl_sel) begin
        mode_r[{ctl_idx, 1'b0} +: 2] <= wdata_i[`CTL_MODE_HI:`CTL_MODE_LO];
        pull_r[ctl_idx] <= wdata_i[`CTL_PULL_BIT];
      end
      if (data_sel)
        data_r[{data_grp, 3'h0} +: `GROUP_WIDTH] <= wdata_i;
      if (otype_sel)
        otype_r[{otype_grp, 3'h0} +: `GROUP_WIDTH] <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // register reads, one cycle after the strobe
  // ----------------------------------------------------------------
  assign level_ext = {{(NBIT-NPIN){1'b0}}, pin_level};

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= {`BUS_DATA_W{1'b0}};
    end else begin
      rdata_o <= {`BUS_DATA_W{1'b0}};
      if (rd_i) begin
        if (ctl_sel) begin
          rdata_o[`CTL_MODE_HI:`CTL_MODE_LO] <= mode_r[{ctl_idx, 1'b0} +: 2];
          rdata_o[`CTL_PULL_BIT] <= pull_r[ctl_idx];
        end else if (data_sel) begin
          // pin level, not the stored bit; lags the pin by the synchroniser
          rdata_o <= level_ext[{data_grp, 3'h0} +: `GROUP_WIDTH];
        end else if (otype_sel) begin
          rdata_o <= otype_r[{otype_grp, 3'h0} +: `GROUP_WIDTH];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin side
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(pin_in_i),
    .sync_o(pin_level)
  );

  assign alt_in_o = pin_level;

  always @* begin
    alt_en_nxt = {NPIN{1'b0}};
    for (j = 0; j < NPIN; j = j + 1) begin
      alt_en_nxt[j] = (mode_r[2*j +: 2] == `MODE_ALT);
    end
  end

  // pull applies in every mode; firmware is trusted not to pull a
  // push-pull output, which only costs power
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pull_en_o <= {`PIN_COUNT{1'b0}};
      pull_down_o <= `PULL_DOWN_MASK;
      alt_en_o <= {`PIN_COUNT{1'b0}};
    end else begin
      pull_en_o <= pull_r;
      pull_down_o <= `PULL_DOWN_MASK;
      alt_en_o <= alt_en_nxt;
    end
  end

  genvar k;
  generate
    for (k = 0; k < NPIN; k = k + 1) begin : g_pin
      pin_drive #(
        .OUTPUT_CAPABLE((k < `PIN_E0) || (k > `PIN_E4))
      ) u_drive (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .mode_i(mode_r[2*k +: 2]),
        .data_i(data_r[k]),
        .od_i(otype_r[k]),
        .alt_out_i(alt_out_i[k]),
        .alt_oe_i(alt_oe_i[k]),
        .pin_out_o(pin_out_o[k]),
        .pin_oe_o(pin_oe_o[k])
      );
    end
  endgenerate
endmodule // gpio_pin_control

// ===== design/pin_drive.v
// registered output driver for one pin
`timescale 1ns/1ns
`include "gpio_pin_consts.vh"
module pin_drive #(
  parameter OUTPUT_CAPABLE = 1
) (
  input wire clk_i,
  input wire resetn_i,
  input wire [1:0] mode_i,
  input wire data_i,
  input wire od_i,
  input wire alt_out_i,
  input wire alt_oe_i,
  output reg pin_out_o,
  output reg pin_oe_o
);
  reg out_nxt;
  reg oe_nxt;

  always @* begin
    out_nxt = 1'b0;
    oe_nxt = 1'b0;
    if (OUTPUT_CAPABLE != 0) begin
      case (mode_i)
        `MODE_OUT: begin
          if (od_i) begin
            out_nxt = 1'b0;
            oe_nxt = ~data_i;
          end else begin
            out_nxt = data_i;
            oe_nxt = 1'b1;
          end
        end
        `MODE_ALT: begin
          // alternate function owns the pin; output type ignored here
          out_nxt = alt_out_i;
          oe_nxt = alt_oe_i;
        end
        default: begin
          // input and the reserved code never drive
          out_nxt = 1'b0;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_out_o <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_out_o <= out_nxt;
      pin_oe_o <= oe_nxt;
    end
  end
endmodule // pin_drive

// ===== design/pin_sync.v
// two-stage synchroniser for pin levels
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire resetn_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;

  // first stage feeds only the second stage
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1_r <= {WIDTH{1'b0}};
      stage2_r <= {WIDTH{1'b0}};
    end else begin
      stage1_r <= async_i;
      stage2_r <= stage1_r;
    end
  end

  assign sync_o = stage2_r;
endmodule // pin_sync

// ===== tb/gpio_pin_control_properties.sv
// assertion checker for the pin control block
`timescale 1ns/1ns
module gpio_pin_control_properties (
  input logic clk_i,
  input logic resetn_i,
  input logic warm_rst_i,
  input logic [7:0] addr_i,
  input logic [7:0] wdata_i,
  input logic wr_i,
  input logic rd_i,
  input logic [7:0] rdata_o,
  input logic [70:0] pin_in_i,
  input logic [70:0] pin_out_o,
  input logic [70:0] pin_oe_o,
  input logic [70:0] pull_en_o,
  input logic [70:0] pull_down_o,
  input logic [70:0] alt_en_o,
  input logic [70:0] alt_out_i,
  input logic [70:0] alt_oe_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // a second write to A0 one cycle later reaches the outputs only after the check, yet the window excludes it
  sequence s_ctl_write;
    wr_i && !warm_rst_i && addr_i == 8'h10 ##1 !warm_rst_i && !(wr_i && addr_i == 8'h10);
  endsequence
  sequence s_quiet;
    $stable(pin_in_i[7:0]) [*3];
  endsequence
  a_pull_follow:
    assert property (s_ctl_write |=> pull_en_o[0] == $past(wdata_i[2], 2))
    else $error("pull enable of A0 differs from written bit");
  a_mode_alt:
    assert property (s_ctl_write |=> alt_en_o[0] == ($past(wdata_i[7:6], 2) == 2'b00))
    else $error("alternate enable of A0 differs from written mode");
  a_e_no_drive:
    assert property (pin_oe_o[36:32] == 5'h00)
    else $error("port E low pin drives");
  a_pull_side:
    assert property (pull_down_o == 71'h00FF_0000_0000_0000)
    else $error("pull direction wrong");
  a_rsvd_zero:
    assert property (rd_i && addr_i >= 8'h10 && addr_i <= 8'h56 |=> (rdata_o & 8'h3B) == 8'h00)
    else $error("reserved control bits read nonzero");
  a_ctl_readback:
    assert property (wr_i && !warm_rst_i && addr_i == 8'h11 ##1 !wr_i && !warm_rst_i
      ##1 rd_i && addr_i == 8'h11 |=> rdata_o == ($past(wdata_i, 3) & 8'hC4))
    else $error("control A1 readback wrong");
  a_data_level:
    assert property (s_quiet ##0 (rd_i && addr_i == 8'h01) |=> rdata_o == $past(pin_in_i[7:0]))
    else $error("group A read is not pin level");
  a_alt_drive:
    assert property (alt_en_o[1] && $past(alt_en_o[1]) |-> pin_out_o[1] == $past(alt_out_i[1])
      && pin_oe_o[1] == $past(alt_oe_i[1]))
    else $error("A1 not driven by alternate function");
endmodule // gpio_pin_control_properties

// ===== tb/pin_board.sv
// board model: pad level from drive, pull and outside level
`timescale 1ns/1ns
module pin_board (
  input logic [70:0] out_i,
  input logic [70:0] oe_i,
  input logic [70:0] pull_en_i,
  input logic [70:0] pull_down_i,
  input logic [70:0] ext_i,
  output logic [70:0] level_o
);
  // released pad falls to its pull, else to the outside level
  assign level_o = (oe_i & out_i) | (~oe_i & pull_en_i & ~pull_down_i)
    | (~oe_i & ~pull_en_i & ext_i);
endmodule // pin_board

// ===== tb/tb_gpio_pin_control.sv
// self-checking bench for the pin control block
`timescale 1ns/1ns
module tb_gpio_pin_control;
  logic clk_i = 1'b0, resetn_i = 1'b0, warm_rst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [70:0] pin_in_i, pin_out_o, pin_oe_o, pull_en_o, pull_down_o, alt_en_o, alt_in_o;
  logic [70:0] alt_out_i = 71'h0, alt_oe_i = 71'h0, ext = 71'h0;
  int err_count = 0, samples_checked = 0;
  gpio_pin_control dut (.clk_i(clk_i), .resetn_i(resetn_i), .warm_rst_i(warm_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pull_en_o(pull_en_o),
    .pull_down_o(pull_down_o), .alt_en_o(alt_en_o), .alt_in_o(alt_in_o), .alt_out_i(alt_out_i),
    .alt_oe_i(alt_oe_i));
  pin_board board (.out_i(pin_out_o), .oe_i(pin_oe_o), .pull_en_i(pull_en_o),
    .pull_down_i(pull_down_o), .ext_i(ext), .level_o(pin_in_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // tasks start and end on a rising edge so requests sit right after it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    // one idle edge so a following write never re-raises the strobe in this step
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("read data", exp, rdata_o);
    @(posedge clk_i);
  endtask
  // out is only defined while the pad is driven
  task automatic pin(input int i, input logic o, input logic e, input logic a);
    repeat (2) @(posedge clk_i);
    #1;
    if (e === 1'b1)
      chk("pin out", {7'h00, o}, {7'h00, pin_out_o[i]});
    chk("pin oe", {7'h00, e}, {7'h00, pin_oe_o[i]});
    chk("alt enable", {7'h00, a}, {7'h00, alt_en_o[i]});
    @(posedge clk_i);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(8'h1D, 8'h40);
    rd(8'h1E, 8'h00);
    rd(8'h10, 8'h80);
    rd(8'h60, 8'h00);
    pin(13, 1'b1, 1'b1, 1'b0);
    pin(14, 1'b0, 1'b0, 1'b1);
    $display("test reset done");
    wr(8'h11, 8'h7B);
    rd(8'h11, 8'h40);
    wr(8'h01, 8'h02);
    pin(1, 1'b1, 1'b1, 1'b0);
    wr(8'h71, 8'h02);
    pin(1, 1'b0, 1'b0, 1'b0);
    wr(8'h01, 8'h00);
    pin(1, 1'b0, 1'b1, 1'b0);
    rd(8'h01, 8'h00);
    $display("test output done");
    wr(8'h11, 8'h80);
    wr(8'h01, 8'h02);
    ext <= 71'h3;
    pin(1, 1'b0, 1'b0, 1'b0);
    rd(8'h01, 8'h03);
    wr(8'h11, 8'hC0);
    pin(1, 1'b0, 1'b0, 1'b0);
    alt_out_i <= 71'h2;
    alt_oe_i <= 71'h2;
    wr(8'h11, 8'h00);
    pin(1, 1'b1, 1'b1, 1'b1);
    wr(8'h71, 8'h00);
    wr(8'h11, 8'h40);
    pin(1, 1'b1, 1'b1, 1'b0);
    wr(8'h30, 8'h40);
    wr(8'h05, 8'h1F);
    pin(32, 1'b0, 1'b0, 1'b0);
    $display("test modes done");
    ext <= 71'h0001_0000_0000_0000;
    wr(8'h40, 8'h84);
    wr(8'h10, 8'h84);
    repeat (4) @(posedge clk_i);
    rd(8'h07, 8'h00);
    rd(8'h01, 8'h03);
    chk("alt in A0", 8'h01, {7'h00, alt_in_o[0]});
    // input mode with pull, so the pull never loads a push-pull driver
    wr(8'h55, 8'h84);
    warm_rst_i <= 1'b1;
    @(posedge clk_i);
    warm_rst_i <= 1'b0;
    rd(8'h55, 8'h84);
    rd(8'h10, 8'h80);
    rd(8'h1D, 8'h40);
    $display("test pull and warm reset done");
    stop_test;
  end
endmodule // tb_gpio_pin_control
bind gpio_pin_control gpio_pin_control_properties chk_props (.clk_i(clk_i),
  .resetn_i(resetn_i), .warm_rst_i(warm_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o), .pull_en_o(pull_en_o), .pull_down_o(pull_down_o),
  .alt_en_o(alt_en_o), .alt_out_i(alt_out_i), .alt_oe_i(alt_oe_i));
